//--- verilog/ppfs_params.svh
// Constants for the port pin function select block
`ifndef PPFS_PARAMS_SVH
`define PPFS_PARAMS_SVH
// Register byte addresses
`define PPFS_ADDR_SEL_LOW   32'hE002C000
`define PPFS_ADDR_SEL_HIGH  32'hE002C004
`define PPFS_ADDR_STATUS    32'hE002C008
`define PPFS_ADDR_ACTIVE    32'hE002C00C
// Reset and idle values
`define PPFS_SEL_RESET      32'h00000000
`define PPFS_READ_IDLE      32'h00000000
// Per-pin function tables, one bit per pin
`define PPFS_FN1_VALID      32'hF83FFFFF
`define PPFS_FN1_OUT        32'h80382501
`define PPFS_FN1_BIDIR      32'h0000007C
`define PPFS_FN2_VALID      32'h0001FFFF
`define PPFS_FN2_OUT        32'h000133AB
`define PPFS_FN2_BIDIR      32'h00000000
// Pins gated by the debug strap
`define PPFS_DBG_PIN_LO     17
// Status register fields
`define PPFS_STAT_DBG_BIT   0
`define PPFS_STAT_RSVD_BIT  1
`endif

//--- verilog/ppfs_pkg.sv
// Types shared by the port pin function select block
package ppfs_pkg;
   // Two-bit pin function code
   typedef enum logic [1:0] {
      PPFS_CODE_GPIO = 2'h0,
      PPFS_CODE_FN1  = 2'h1,
      PPFS_CODE_FN2  = 2'h2,
      PPFS_CODE_RSVD = 2'h3
   } ppfs_code_e;
   // One peripheral's drive onto one pin
   typedef struct packed {
      logic out;
      logic oe;
   } ppfs_drive_s;
   // Whole-port pad drive
   typedef struct packed {
      logic [31:0] out;
      logic [31:0] oe;
   } ppfs_pad_s;
endpackage

//--- verilog/ppfs_sync.sv
// Two-stage synchroniser for levels entering the clock domain
`timescale 1ns/1ns
module ppfs_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             clk_i,   // Block clock
   input  wire logic             rst_i,   // Sync reset, high
   input  wire logic [WIDTH-1:0] async_i, // Unsynchronised level
   output logic      [WIDTH-1:0] sync_o   // Synchronised level
);
   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] sync_q;

   // First stage feeds only the second
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= async_i;
         sync_q <= meta_q;
      end
   end

   assign sync_o = sync_q;
endmodule

//--- verilog/ppfs_pin_cell.sv
// Function multiplexer for a single port pin
`timescale 1ns/1ns
module ppfs_pin_cell #(
   parameter bit FN1_VALID = 1'b0,
   parameter bit FN1_OUT   = 1'b0,
   parameter bit FN1_BIDIR = 1'b0,
   parameter bit FN2_VALID = 1'b0,
   parameter bit FN2_OUT   = 1'b0,
   parameter bit FN2_BIDIR = 1'b0
) (
   input  wire logic [1:0]          code_i,   // Effective selector
   input  wire logic                gpio_out_i, // GPIO output value
   input  wire logic                gpio_dir_i, // GPIO direction bit
   input  wire ppfs_pkg::ppfs_drive_s fn1_i,  // Function 1 drive
   input  wire ppfs_pkg::ppfs_drive_s fn2_i,  // Function 2 drive
   input  wire logic                pad_in_i, // Synchronised pad level
   output logic                     pad_out_o, // Pad output value
   output logic                     pad_oe_o, // Pad output enable
   output logic                     fn1_in_o, // Pad to function 1
   output logic                     fn2_in_o, // Pad to function 2
   output logic                     rsvd_o    // Reserved code in use
);
   // Decode of the pin's function code
   always_comb begin
      pad_out_o = gpio_out_i;
      pad_oe_o  = gpio_dir_i;
      fn1_in_o  = 1'b0;
      fn2_in_o  = 1'b0;
      rsvd_o    = 1'b0;
      case (code_i)
         ppfs_pkg::PPFS_CODE_GPIO: begin
            pad_oe_o = gpio_dir_i;
         end
         ppfs_pkg::PPFS_CODE_FN1: begin
            pad_out_o = fn1_i.out;
            pad_oe_o  = FN1_VALID & (FN1_OUT | (FN1_BIDIR & fn1_i.oe));
            fn1_in_o  = FN1_VALID & pad_in_i;
            rsvd_o    = ~FN1_VALID;
         end
         ppfs_pkg::PPFS_CODE_FN2: begin
            pad_out_o = fn2_i.out;
            pad_oe_o  = FN2_VALID & (FN2_OUT | (FN2_BIDIR & fn2_i.oe));
            fn2_in_o  = FN2_VALID & pad_in_i;
            rsvd_o    = ~FN2_VALID;
         end
         default: begin
            // Reserved code leaves the pad undriven
            pad_oe_o = 1'b0;
            rsvd_o   = 1'b1;
         end
      endcase
   end
endmodule

//--- verilog/ppfs_top.sv
// Port pin function select: registers, strap and pin multiplexers
//
// The implementer's own choice: the Wishbone slave port.
`timescale 1ns/1ns
`include "ppfs_params.svh"
module ppfs_top (
   input  wire logic                         clk_i,      // 25 MHz clock
   input  wire logic                         rst_i,      // Sync reset, high
   // Wishbone slave
   input  wire logic                         cyc_i,      // Bus cycle
   input  wire logic                         stb_i,      // Strobe
   input  wire logic                         we_i,       // Write enable
   input  wire logic [31:0]                  adr_i,      // Byte address
   input  wire logic [3:0]                   sel_i,      // Byte lanes
   input  wire logic [31:0]                  dat_i,      // Write data
   output logic      [31:0]                  dat_o,      // Read data
   output logic                              ack_o,      // Acknowledge
   // Strap pin
   input  wire logic                         debug_select_input_i, // Debug strap
   output logic                              debug_mode_o, // Strap latched high
   // GPIO logic side
   input  wire logic [31:0]                  gpio_out_i, // GPIO output values
   input  wire logic [31:0]                  gpio_direction_register_i, // 1 = out
   output logic      [31:0]                  gpio_in_o,  // Pad levels to GPIO
   // Peripheral side
   input  wire ppfs_pkg::ppfs_drive_s [31:0] fn1_drv_i,  // Code 01 drives
   input  wire ppfs_pkg::ppfs_drive_s [31:0] fn2_drv_i,  // Code 10 drives
   output logic      [31:0]                  fn1_in_o,   // Pads to code 01
   output logic      [31:0]                  fn2_in_o,   // Pads to code 10
   // Pad side
   input  wire logic [31:0]                  pad_in_i,   // Pad levels
   output ppfs_pkg::ppfs_pad_s               pad_o       // Pad drive
);

   ////////////////////////////////////////////////////////////////////////
   // Declarations
   ////////////////////////////////////////////////////////////////////////

   // Selector registers
   logic [31:0]         sel_low_q;
   logic [31:0]         sel_high_q;
   logic [63:0]         sel_all;

   // Bus side
   logic                bus_req;
   logic                wr_now;
   logic                hit_low;
   logic                hit_high;
   logic                hit_status;
   logic                hit_active;
   logic [31:0]         wr_mask;
   logic [31:0]         rd_d;
   logic [31:0]         status_word;
   logic                ack_q;
   logic [31:0]         dat_q;

   // Strap
   logic                strap_q;
   logic                dbg_sync;

   // Per-pin multiplexer results
   logic [31:0]         pad_sync;
   logic [31:0]         pin_out;
   logic [31:0]         pin_oe;
   logic [31:0]         pin_fn1_in;
   logic [31:0]         pin_fn2_in;
   logic [31:0]         pin_rsvd;
   logic [31:0]         pin_active;

   // Output registers
   ppfs_pkg::ppfs_pad_s pad_q;
   logic [31:0]         gpio_in_q;
   logic [31:0]         fn1_in_q;
   logic [31:0]         fn2_in_q;

   ////////////////////////////////////////////////////////////////////////
   // Pin function tables
   ////////////////////////////////////////////////////////////////////////

   // Pins with a code 01 function; 22 to 26 have none
   localparam logic [31:0] FN1_VALID_TBL = `PPFS_FN1_VALID;
   // Code 01 functions that always drive the pad
   localparam logic [31:0] FN1_OUT_TBL   = `PPFS_FN1_OUT;
   // Code 01 functions whose peripheral sets direction
   localparam logic [31:0] FN1_BIDIR_TBL = `PPFS_FN1_BIDIR;
   // Pins with a code 10 function; 17 to 31 have none
   localparam logic [31:0] FN2_VALID_TBL = `PPFS_FN2_VALID;
   // Code 10 functions that always drive the pad
   localparam logic [31:0] FN2_OUT_TBL   = `PPFS_FN2_OUT;
   // Code 10 functions whose peripheral sets direction
   localparam logic [31:0] FN2_BIDIR_TBL = `PPFS_FN2_BIDIR;

   ////////////////////////////////////////////////////////////////////////
   // Pin input synchronisers
   ////////////////////////////////////////////////////////////////////////

   // Pad levels into the clock domain
   ppfs_sync #(
      .WIDTH (32)
   ) u_pad_sync (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .async_i (pad_in_i),
      .sync_o  (pad_sync)
   );

   // Debug strap into the clock domain; kept out of
   // reset so the level reaches the latch while reset holds
   ppfs_sync #(
      .WIDTH (1)
   ) u_dbg_sync (
      .clk_i   (clk_i),
      .rst_i   (1'b0),
      .async_i (debug_select_input_i),
      .sync_o  (dbg_sync)
   );

   ////////////////////////////////////////////////////////////////////////
   // Debug strap capture
   ////////////////////////////////////////////////////////////////////////

   // strap sampled during reset
   // Held outside reset; needs three reset edges
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         strap_q <= dbg_sync;
      end
   end

   assign debug_mode_o = strap_q;

   ////////////////////////////////////////////////////////////////////////
   // Wishbone decode
   ////////////////////////////////////////////////////////////////////////

   // Request present on the bus
   assign bus_req    = cyc_i & stb_i;

   // Address match per register, full address compared
   assign hit_low    = (adr_i == `PPFS_ADDR_SEL_LOW);
   assign hit_high   = (adr_i == `PPFS_ADDR_SEL_HIGH);
   assign hit_status = (adr_i == `PPFS_ADDR_STATUS);
   assign hit_active = (adr_i == `PPFS_ADDR_ACTIVE);

   // Write lands at the edge the master sees ack,
   // so a held request never writes twice
   assign wr_now = bus_req & we_i & ack_q;

   // Byte lane mask for writes, one lane per select bit
   for (genvar b = 0; b < 4; b++) begin : g_lane
      assign wr_mask[8*b +: 8] = {8{sel_i[b]}};
   end

   ////////////////////////////////////////////////////////////////////////
   // Read data path
   ////////////////////////////////////////////////////////////////////////

   // Status word: strap and reserved-code flag
   always_comb begin
      status_word                      = `PPFS_READ_IDLE;
      status_word[`PPFS_STAT_DBG_BIT]  = strap_q;
      status_word[`PPFS_STAT_RSVD_BIT] = |pin_rsvd;
   end

   // both words read back whole
   // Read data select; unmapped reads zero
   always_comb begin
      rd_d = `PPFS_READ_IDLE;
      if (hit_low) begin
         rd_d = sel_low_q;
      end else if (hit_high) begin
         rd_d = sel_high_q;
      end else if (hit_status) begin
         rd_d = status_word;
      end else if (hit_active) begin
         rd_d = pin_active;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Wishbone handshake
   ////////////////////////////////////////////////////////////////////////

   // One ack per request, dropped the cycle after
   // Ack low again before a new request is taken
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= bus_req & ~ack_q;
      end
   end

   // Read data captured with the ack
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dat_q <= `PPFS_READ_IDLE;
      end else if (bus_req & ~ack_q & ~we_i) begin
         dat_q <= rd_d;
      end
   end

   assign ack_o = ack_q;
   assign dat_o = dat_q;

   ////////////////////////////////////////////////////////////////////////
   // Selector registers
   ////////////////////////////////////////////////////////////////////////

   // Partial-lane writes keep the other bytes
   // all fields clear to GPIO
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sel_low_q <= `PPFS_SEL_RESET;
      end else if (wr_now & hit_low) begin
         sel_low_q <= (sel_low_q & ~wr_mask) | (dat_i & wr_mask);
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sel_high_q <= `PPFS_SEL_RESET;
      end else if (wr_now & hit_high) begin
         sel_high_q <= (sel_high_q & ~wr_mask) | (dat_i & wr_mask);
      end
   end

   // Fields of both registers in pin order
   assign sel_all = {sel_high_q, sel_low_q};

   ////////////////////////////////////////////////////////////////////////
   // Pin multiplexers
   ////////////////////////////////////////////////////////////////////////

   // One cell per pin; tables fix each pin's functions
   for (genvar n = 0; n < 32; n++) begin : g_pin
      // Effective code after the strap
      logic [1:0] code;

      // strap high forces GPIO above pin 16
      if (n >= `PPFS_DBG_PIN_LO) begin : g_dbg
         assign code = strap_q ? ppfs_pkg::PPFS_CODE_GPIO : sel_all[2*n +: 2];
      end else begin : g_plain
         assign code = sel_all[2*n +: 2];
      end

      // function multiplexer for pin n, set by its table bits
      ppfs_pin_cell #(
         .FN1_VALID (FN1_VALID_TBL[n]),
         .FN1_OUT   (FN1_OUT_TBL[n]),
         .FN1_BIDIR (FN1_BIDIR_TBL[n]),
         .FN2_VALID (FN2_VALID_TBL[n]),
         .FN2_OUT   (FN2_OUT_TBL[n]),
         .FN2_BIDIR (FN2_BIDIR_TBL[n])
      ) u_cell (
         .code_i     (code),
         .gpio_out_i (gpio_out_i[n]),
         .gpio_dir_i (gpio_direction_register_i[n]),
         .fn1_i      (fn1_drv_i[n]),
         .fn2_i      (fn2_drv_i[n]),
         .pad_in_i   (pad_sync[n]),
         .pad_out_o  (pin_out[n]),
         .pad_oe_o   (pin_oe[n]),
         .fn1_in_o   (pin_fn1_in[n]),
         .fn2_in_o   (pin_fn2_in[n]),
         .rsvd_o     (pin_rsvd[n])
      );

      // Pin routed to a peripheral
      assign pin_active[n] = (code != ppfs_pkg::PPFS_CODE_GPIO) & ~pin_rsvd[n];
   end

   ////////////////////////////////////////////////////////////////////////
   // Output registers
   ////////////////////////////////////////////////////////////////////////

   // Registered so a selector write never glitches a pad
   // Pad drive; all pads undriven in reset
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pad_q.out <= '0;
         pad_q.oe  <= '0;
      end else begin
         pad_q.out <= pin_out;
         pad_q.oe  <= pin_oe;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Pad levels back inward
   ////////////////////////////////////////////////////////////////////////

   // Pad levels to GPIO whatever the pin's function
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         gpio_in_q <= '0;
      end else begin
         gpio_in_q <= pad_sync;
      end
   end

   // Pad levels to the selected peripheral only
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         fn1_in_q  <= '0;
         fn2_in_q  <= '0;
      end else begin
         fn1_in_q  <= pin_fn1_in;
         fn2_in_q  <= pin_fn2_in;
      end
   end

   assign pad_o     = pad_q;
   assign gpio_in_o = gpio_in_q;
   assign fn1_in_o  = fn1_in_q;
   assign fn2_in_o  = fn2_in_q;

endmodule

//--- sim/ppfs_periph_model.sv
// Peripheral, GPIO and pad-side model for the pin multiplexer
`timescale 1ns/1ns
module ppfs_periph_model (
   input  wire logic [31:0]             pat_i,      // Peripheral levels
   input  wire logic [31:0]             dir_i,      // GPIO direction
   input  wire logic [31:0]             ext_i,      // Off-chip levels
   input  wire ppfs_pkg::ppfs_pad_s     pad_i,      // Pad drive
   output ppfs_pkg::ppfs_drive_s [31:0] fn1_o,      // Code 01 drives
   output ppfs_pkg::ppfs_drive_s [31:0] fn2_o,      // Code 10 drives
   output logic [31:0]                  gpio_out_o, // GPIO values
   output logic [31:0]                  gpio_dir_o, // GPIO direction
   output logic [31:0]                  pad_in_o    // Pad levels
);
   // Peripherals drive fixed patterns, enable follows data
   always_comb begin
      for (int n = 0; n < 32; n++) begin
         fn1_o[n] = {pat_i[n], pat_i[n]};
         fn2_o[n] = {~pat_i[n], ~pat_i[n]};
      end
   end
   // GPIO logic side
   assign gpio_out_o = pat_i ^ dir_i;
   assign gpio_dir_o = dir_i;
   // Driven pads show the drive, others the off-chip level
   assign pad_in_o = (pad_i.oe & pad_i.out) | (~pad_i.oe & ext_i);
endmodule

//--- sim/ppfs_properties.sv
// Checker for the port pin function select block
`timescale 1ns/1ns
`include "ppfs_params.svh"
module ppfs_props (
   input wire logic                         clk_i,        // Clock
   input wire logic                         rst_i,        // Reset
   input wire logic                         cyc_i,        // Cycle
   input wire logic                         stb_i,        // Strobe
   input wire logic                         we_i,         // Write
   input wire logic [31:0]                  adr_i,        // Address
   input wire logic [3:0]                   sel_i,        // Lanes
   input wire logic [31:0]                  dat_i,        // Write data
   input wire logic [31:0]                  dat_o,        // Read data
   input wire logic                         ack_o,        // Ack
   input wire logic                         debug_mode_o, // Strap state
   input wire logic [31:0]                  gpio_out_i,   // GPIO values
   input wire logic [31:0]                  gpio_direction_register_i, // GPIO dir
   input wire ppfs_pkg::ppfs_drive_s [31:0] fn1_drv_i,    // Code 01 drives
   input wire ppfs_pkg::ppfs_pad_s          pad_o         // Pad drive
);
   logic [31:0] lo_q;
   logic [31:0] hi_q;
   logic [31:0] m;
   assign m = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
   // Shadow copy of both selector words
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         lo_q <= '0;
         hi_q <= '0;
      end else if (cyc_i && stb_i && we_i && ack_o) begin
         if (adr_i == `PPFS_ADDR_SEL_LOW) lo_q <= (lo_q & ~m) | (dat_i & m);
         if (adr_i == `PPFS_ADDR_SEL_HIGH) hi_q <= (hi_q & ~m) | (dat_i & m);
      end
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence s_take; cyc_i && stb_i && !ack_o; endsequence
   sequence s_rd(a); s_take ##0 !we_i && adr_i == a ##1 ack_o; endsequence
   property p_ack; s_take |=> ack_o ##1 !ack_o; endproperty
   a_ack: assert property (p_ack) else $error("ack not a single pulse");
   property p_rd_lo; s_rd(`PPFS_ADDR_SEL_LOW) |-> dat_o == lo_q; endproperty
   a_rd_lo: assert property (p_rd_lo) else $error("low select readback");
   property p_rd_hi; s_rd(`PPFS_ADDR_SEL_HIGH) |-> dat_o == hi_q; endproperty
   a_rd_hi: assert property (p_rd_hi) else $error("high select readback");
   property p_gpio;
      lo_q[1:0] == 2'h0 |=> pad_o.oe[0] == $past(gpio_direction_register_i[0])
         && (!pad_o.oe[0] || pad_o.out[0] == $past(gpio_out_i[0]));
   endproperty
   a_gpio: assert property (p_gpio) else $error("pin 0 gpio drive");
   property p_fn_out; lo_q[1:0] == 2'h1 |=> pad_o.oe[0] && pad_o.out[0] == $past(fn1_drv_i[0].out); endproperty
   a_fn_out: assert property (p_fn_out) else $error("pin 0 transmit drive");
   property p_fn_in; lo_q[3:2] == 2'h1 |=> !pad_o.oe[1]; endproperty
   a_fn_in: assert property (p_fn_in) else $error("pin 1 receive drives");
   property p_tdo;
      !debug_mode_o && hi_q[31:30] == 2'h1 |=> pad_o.oe[31] && pad_o.out[31] == $past(fn1_drv_i[31].out);
   endproperty
   a_tdo: assert property (p_tdo) else $error("pin 31 test output");
   property p_strap; debug_mode_o |=> pad_o.oe[27] == $past(gpio_direction_register_i[27]); endproperty
   a_strap: assert property (p_strap) else $error("pin 27 not gpio under strap");
endmodule
bind ppfs_top ppfs_props u_props (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o,
   .debug_mode_o, .gpio_out_i, .gpio_direction_register_i, .fn1_drv_i, .pad_o);

//--- sim/tb_port_pin_function_select.sv
// Self-checking bench for the port pin function select block
`timescale 1ns/1ns
`include "ppfs_params.svh"
module tb_port_pin_function_select;
   logic                         clk_i = 1'b0;
   logic                         rst_i = 1'b1;
   logic                         cyc = 1'b0;
   logic                         stb = 1'b0;
   logic                         we = 1'b0;
   logic                         strap = 1'b0;
   logic [31:0]                  adr = '0;
   logic [31:0]                  wdat = '0;
   logic [3:0]                   sel = 4'hF;
   logic [31:0]                  pat = 32'hA5C35A3C;
   logic [31:0]                  dir = 32'h0F0F3C3C;
   logic [31:0]                  ext = 32'h3355AACC;
   logic [31:0]                  v1 = `PPFS_FN1_VALID;
   logic [31:0]                  o1 = `PPFS_FN1_OUT;
   logic [31:0]                  b1 = `PPFS_FN1_BIDIR;
   logic [31:0]                  v2 = `PPFS_FN2_VALID;
   logic [31:0]                  o2 = `PPFS_FN2_OUT;
   logic [31:0]                  rd, dat_o, gpio_out, gpio_dir, gpio_in, fn1_in, fn2_in, pad_in, lvl;
   logic                         ack_o, dbg, eo, ev;
   ppfs_pkg::ppfs_drive_s [31:0] fn1, fn2;
   ppfs_pkg::ppfs_pad_s          pad;
   int                           fails = 0;
   int                           checks = 0;
   ppfs_top dut (.clk_i, .rst_i, .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat),
      .dat_o, .ack_o, .debug_select_input_i(strap), .debug_mode_o(dbg), .gpio_out_i(gpio_out),
      .gpio_direction_register_i(gpio_dir), .gpio_in_o(gpio_in), .fn1_drv_i(fn1), .fn2_drv_i(fn2),
      .fn1_in_o(fn1_in), .fn2_in_o(fn2_in), .pad_in_i(pad_in), .pad_o(pad));
   ppfs_periph_model u_model (.pat_i(pat), .dir_i(dir), .ext_i(ext), .pad_i(pad), .fn1_o(fn1), .fn2_o(fn2),
      .gpio_out_o(gpio_out), .gpio_dir_o(gpio_dir), .pad_in_o(pad_in));
   // 25 MHz clock
   always #20 clk_i = ~clk_i;
   ////////////////////////////////////////////////////////////////////////////
   // Compare and report
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         fails++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // Print verdict and end the run
   task automatic stop_test;
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // One classic bus cycle, held until ack
   task automatic wb(input logic w, input logic [31:0] a, input logic [31:0] d, input logic [3:0] s);
      int k;
      k = 0;
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      sel <= s;
      do begin
         @(posedge clk_i);
         k++;
      end while (ack_o !== 1'b1 && k < 50);
      rd = dat_o;
      chk("ack seen", {31'h0, k < 50}, 32'h00000001);
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   // Reset with a given strap level
   task automatic do_reset(input logic s);
      @(posedge clk_i);
      strap <= s;
      rst_i <= 1'b1;
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   // Test sequence
   initial begin
      do_reset(1'b0);
      wb(1'b0, `PPFS_ADDR_SEL_LOW, '0, 4'hF);
      chk("low reset", rd, `PPFS_SEL_RESET);
      wb(1'b0, `PPFS_ADDR_SEL_HIGH, '0, 4'hF);
      chk("high reset", rd, `PPFS_SEL_RESET);
      repeat (4) @(posedge clk_i);
      lvl = (dir & (pat ^ dir)) | (~dir & ext);
      chk("gpio oe", pad.oe, dir);
      chk("gpio out", pad.out & dir, (pat ^ dir) & dir);
      chk("gpio in", gpio_in, lvl);
      chk("fn1 in", fn1_in, 32'h00000000);
      $display("test reset done");
      wb(1'b1, `PPFS_ADDR_SEL_LOW, 32'h12345678, 4'hF);
      wb(1'b1, `PPFS_ADDR_SEL_LOW, 32'hFFFFFFFF, 4'h2);
      wb(1'b1, 32'hE002C010, 32'hFFFFFFFF, 4'hF);
      wb(1'b0, `PPFS_ADDR_SEL_LOW, '0, 4'hF);
      chk("low lanes", rd, 32'h1234FF78);
      wb(1'b1, `PPFS_ADDR_SEL_HIGH, 32'h9ABCDEF0, 4'hF);
      wb(1'b0, `PPFS_ADDR_SEL_HIGH, '0, 4'hF);
      chk("high word", rd, 32'h9ABCDEF0);
      wb(1'b0, 32'hE002C010, '0, 4'hF);
      chk("unmapped", rd, 32'h00000000);
      wb(1'b1, `PPFS_ADDR_SEL_LOW, '0, 4'hF);
      wb(1'b1, `PPFS_ADDR_SEL_HIGH, '0, 4'hF);
      $display("test readback done");
      for (int n = 0; n < 32; n++) begin
         for (int c = 1; c < 4; c++) begin
            wb(1'b1, n < 16 ? `PPFS_ADDR_SEL_LOW : `PPFS_ADDR_SEL_HIGH, 32'(c) << (2 * (n % 16)), 4'hF);
            repeat (5) @(posedge clk_i);
            ev = c == 1 ? v1[n] : c == 2 ? v2[n] : 1'b0;
            eo = ev & (c == 1 ? (b1[n] ? pat[n] : o1[n]) : o2[n]);
            lvl[0] = eo ? (c == 1 ? pat[n] : ~pat[n]) : ext[n];
            chk("pin oe", pad.oe[n], eo);
            chk("pin out", pad.out[n] & eo, lvl[0] & eo);
            chk("fn1 in", fn1_in[n], ev & c == 1 & lvl[0]);
            chk("fn2 in", fn2_in[n], ev & c == 2 & lvl[0]);
            chk("gpio in", gpio_in[n], lvl[0]);
            wb(1'b0, `PPFS_ADDR_ACTIVE, '0, 4'hF);
            chk("active", rd, 32'(ev) << n);
            wb(1'b0, `PPFS_ADDR_STATUS, '0, 4'hF);
            chk("status", rd, {30'h0, ~ev, 1'b0});
         end
         wb(1'b1, n < 16 ? `PPFS_ADDR_SEL_LOW : `PPFS_ADDR_SEL_HIGH, '0, 4'hF);
      end
      $display("test pin codes done");
      // strap high keeps upper pins on GPIO
      do_reset(1'b1);
      wb(1'b1, `PPFS_ADDR_SEL_HIGH, 32'h55555555, 4'hF);
      repeat (2) @(posedge clk_i);
      chk("strap", dbg, 32'h00000001);
      chk("strap oe", pad.oe[31:17], dir[31:17]);
      chk("pin 16 oe", pad.oe[16], 32'h00000000);
      wb(1'b0, `PPFS_ADDR_SEL_HIGH, '0, 4'hF);
      chk("strap readback", rd, 32'h55555555);
      wb(1'b0, `PPFS_ADDR_STATUS, '0, 4'hF);
      chk("strap status", rd, 32'h00000001);
      $display("test strap done");
      stop_test;
   end
   // Watchdog against a hung run
   initial begin
      repeat (20000) @(posedge clk_i);
      fails++;
      stop_test;
   end
endmodule
